// [kbcefg_params.svh]
// Offsets, field positions, codes and reset values of the keyboard-controller assist block
`ifndef KBCEFG_PARAMS_SVH
`define KBCEFG_PARAMS_SVH

// ****************************************
// Host I/O decode
// ****************************************
`define KBCEFG_KBC_BASE_DEF 16'h0060
`define KBCEFG_HOST_DATA_OFS 16'h0000
`define KBCEFG_HOST_CMD_OFS 16'h0004
`define KBCEFG_FAST_RESET_ADDR 16'h0092

// ****************************************
// Embedded-controller offsets
// ****************************************
`define KBCEFG_EC_KBD_DATA 12'h000
`define KBCEFG_EC_STATUS 12'h004
`define KBCEFG_EC_CONTROL 12'h008
`define KBCEFG_AUX_OUTPUT_DATA_WRITE 12'h00C
`define KBCEFG_EC_KBD_FLAG 12'h014
`define KBCEFG_EC_ACTIVATE 12'h030
`define KBCEFG_EC_FR_ENABLE 12'h040
`define KBCEFG_EC_FR_BAR 12'h044
`define KBCEFG_EC_GATE_CTRL 12'h100
`define KBCEFG_EC_GATE_SET 12'h104
`define KBCEFG_EC_GATE_CLR 12'h108

// ****************************************
// Field positions
// ****************************************
`define KBCEFG_ST_OBF 0
`define KBCEFG_ST_IBF 1
`define KBCEFG_ST_CD 3
`define KBCEFG_ST_AUX 5
`define KBCEFG_CTL_IRQEN 0
`define KBCEFG_CTL_KBDFW 1
`define KBCEFG_CTL_AUXFW 2
`define KBCEFG_CTL_GATEOVR 3
`define KBCEFG_FR_RST_BIT 0
`define KBCEFG_FR_GATE_BIT 1
`define KBCEFG_GATE_DATA_BIT 1

// ****************************************
// Host commands and reset values
// ****************************************
`define KBCEFG_CMD_GATE 8'hD1
`define KBCEFG_CMD_NOP 8'hFF
`define KBCEFG_CMD_PULSE 8'hFE
`define KBCEFG_FAST_RESET_RST 8'h00

`endif

// [kbcefg_pkg.sv]
// Types shared by the keyboard-controller assist block
package kbcefg_pkg;

  typedef enum logic [1:0] {
    GT_IDLE,
    GT_WAIT_DATA,
    GT_GOT_DATA
  } kbcefg_gate_st_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } kbcefg_host_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } kbcefg_ec_req_t;

  typedef struct packed {
    logic [7:0] out_data;
    logic [7:0] in_data;
    logic out_full_flag;
    logic in_full_flag;
    logic cd;
    logic aux_flag;
    logic [3:0] ud;
    logic kbd_track;
    logic kbd_latch;
    logic irq_en;
    logic kbd_fw_sel;
    logic aux_fw_sel;
    logic gate_ovr;
    logic gate_fw;
    logic gate_host;
    kbcefg_gate_st_t gate_st;
    logic activate;
    logic fr_enable;
    logic fr_valid;
    logic [7:0] fast_reset;
    logic [7:0] host_rdata;
    logic host_rdata_oe;
    logic [7:0] ec_rdata;
    logic keyboard_irq;
    logic mouse_irq;
    logic addr_line_gate;
    logic alt_line_gate;
    logic alt_host_reset_n;
  } kbcefg_state_t;

endpackage

// [kbcefg_core.sv]
// Keyboard-controller assists: output flags, interrupt gating, address-line gate, fast-reset port
`timescale 1ns/100ps
`default_nettype none
`include "kbcefg_params.svh"

module kbcefg_core
  import kbcefg_pkg::*;
#(
  parameter logic [15:0] KBC_BASE = `KBCEFG_KBC_BASE_DEF
) (
  // Clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic io_domain_reset_n,
  // Power control
  input wire logic low_power_req,
  // Host I/O cycles
  input wire kbcefg_host_req_t host_req,
  output logic [7:0] host_rdata,
  output logic host_rdata_oe,
  // Embedded-controller bus
  input wire kbcefg_ec_req_t ec_req,
  output logic [7:0] ec_rdata,
  // System signals
  output logic keyboard_irq,
  output logic mouse_irq,
  output logic addr_line_gate,
  output logic alt_line_gate,
  output logic alt_host_reset_n
);

  // ****************************************
  // Host decode
  // ****************************************
  localparam logic [15:0] DATA_PORT = 16'(KBC_BASE + `KBCEFG_HOST_DATA_OFS);
  localparam logic [15:0] CMD_PORT = 16'(KBC_BASE + `KBCEFG_HOST_CMD_OFS);
  // Fixed port; only the valid bit of its base register is writable
  localparam logic [15:0] FAST_RESET_PORT = `KBCEFG_FAST_RESET_ADDR;

  // ****************************************
  // State
  // ****************************************
  localparam kbcefg_state_t STATE_RST = '{
    out_data: 8'h00,
    in_data: 8'h00,
    out_full_flag: 1'b0,
    in_full_flag: 1'b0,
    cd: 1'b0,
    aux_flag: 1'b0,
    ud: 4'h0,
    kbd_track: 1'b0,
    kbd_latch: 1'b0,
    irq_en: 1'b0,
    kbd_fw_sel: 1'b0,
    aux_fw_sel: 1'b0,
    gate_ovr: 1'b0,
    gate_fw: 1'b0,
    gate_host: 1'b0,
    gate_st: GT_IDLE,
    activate: 1'b0,
    fr_enable: 1'b0,
    fr_valid: 1'b0,
    fast_reset: `KBCEFG_FAST_RESET_RST,
    host_rdata: 8'h00,
    host_rdata_oe: 1'b0,
    ec_rdata: 8'h00,
    keyboard_irq: 1'b0,
    mouse_irq: 1'b0,
    addr_line_gate: 1'b0,
    alt_line_gate: 1'b0,
    alt_host_reset_n: 1'b1
  };

  kbcefg_state_t state_reg;
  kbcefg_state_t state_next;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] status_byte(input kbcefg_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[`KBCEFG_ST_OBF] = s.out_full_flag;
    b[`KBCEFG_ST_IBF] = s.in_full_flag;
    b[`KBCEFG_ST_CD] = s.cd;
    b[`KBCEFG_ST_AUX] = s.aux_flag;
    // Free bits belong to firmware
    b[2] = s.ud[0];
    b[4] = s.ud[1];
    b[6] = s.ud[2];
    b[7] = s.ud[3];
    status_byte = b;
  endfunction

  function automatic logic [7:0] control_byte(input kbcefg_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[`KBCEFG_CTL_IRQEN] = s.irq_en;
    b[`KBCEFG_CTL_KBDFW] = s.kbd_fw_sel;
    b[`KBCEFG_CTL_AUXFW] = s.aux_fw_sel;
    b[`KBCEFG_CTL_GATEOVR] = s.gate_ovr;
    control_byte = b;
  endfunction

  function automatic logic kbd_flag(input kbcefg_state_t s);
    kbd_flag = s.kbd_fw_sel ? s.kbd_latch : s.kbd_track;
  endfunction

  function automatic logic gate_value(input kbcefg_state_t s);
    gate_value = s.gate_ovr ? s.gate_fw : s.gate_host;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic hit_data;
  logic hit_cmd;
  logic hit_fr;
  logic [7:0] cmd;

  always_comb begin
    state_next = state_reg;
    hit_data = state_reg.activate && (host_req.addr == DATA_PORT);
    hit_cmd = state_reg.activate && (host_req.addr == CMD_PORT);
    hit_fr = state_reg.fr_enable && state_reg.fr_valid
      && (host_req.addr == FAST_RESET_PORT);
    cmd = host_req.wdata;
    // All state but the fast-reset port and its two lines freezes in low power, as if the clock were stopped
    if (!low_power_req) begin
      state_next.host_rdata = 8'h00;
      state_next.host_rdata_oe = 1'b0;
      state_next.ec_rdata = 8'h00;

      // Firmware reads; input-full clear comes first so a host write wins
      if (ec_req.rd) begin
        case (ec_req.addr)
          `KBCEFG_EC_KBD_DATA: begin
            state_next.ec_rdata = state_reg.in_data;
            state_next.in_full_flag = 1'b0;
          end
          `KBCEFG_EC_STATUS: begin
            state_next.ec_rdata = status_byte(state_reg);
          end
          `KBCEFG_EC_CONTROL: begin
            state_next.ec_rdata = control_byte(state_reg);
          end
          `KBCEFG_EC_KBD_FLAG: begin
            state_next.ec_rdata = {7'h00, kbd_flag(state_reg)};
          end
          `KBCEFG_EC_ACTIVATE: begin
            state_next.ec_rdata = {7'h00, state_reg.activate};
          end
          `KBCEFG_EC_FR_ENABLE: begin
            state_next.ec_rdata = {7'h00, state_reg.fr_enable};
          end
          `KBCEFG_EC_FR_BAR: begin
            state_next.ec_rdata = {7'h00, state_reg.fr_valid};
          end
          `KBCEFG_EC_GATE_CTRL: begin
            state_next.ec_rdata = {7'h00, gate_value(state_reg)};
          end
          default: begin
            state_next.ec_rdata = 8'h00;
          end
        endcase
      end

      // Host reads
      if (host_req.rd) begin
        if (hit_data) begin
          state_next.host_rdata = state_reg.out_data;
          state_next.host_rdata_oe = 1'b1;
          state_next.out_full_flag = 1'b0;
          state_next.kbd_track = 1'b0;
          if (!state_reg.aux_fw_sel) begin
            state_next.aux_flag = 1'b0;
          end
        end else if (hit_cmd) begin
          state_next.host_rdata = status_byte(state_reg);
          state_next.host_rdata_oe = 1'b1;
        end else if (hit_fr) begin
          state_next.host_rdata = state_reg.fast_reset;
          state_next.host_rdata_oe = 1'b1;
        end
      end

      // Host command writes and the gate sequence
      if (host_req.wr && hit_cmd) begin
        case (state_reg.gate_st)
          GT_WAIT_DATA: begin
            if (cmd == `KBCEFG_CMD_GATE) begin
              state_next.gate_st = GT_WAIT_DATA;
            end else begin
              // Anything but D1 here breaks the sequence; firmware must see it
              state_next.in_data = cmd;
              state_next.cd = 1'b1;
              state_next.in_full_flag = 1'b1;
              state_next.gate_st = GT_IDLE;
            end
          end
          default: begin
            if (cmd == `KBCEFG_CMD_GATE) begin
              state_next.gate_st = GT_WAIT_DATA;
            end else if (cmd == `KBCEFG_CMD_NOP || cmd == `KBCEFG_CMD_PULSE) begin
              state_next.gate_st = GT_IDLE;
            end else begin
              state_next.in_data = cmd;
              state_next.cd = 1'b1;
              state_next.in_full_flag = 1'b1;
              state_next.gate_st = GT_IDLE;
            end
          end
        endcase
      end

      // Host data writes
      // A data byte feeds the gate only right after D1
      if (host_req.wr && hit_data) begin
        case (state_reg.gate_st)
          GT_WAIT_DATA: begin
            state_next.gate_host = cmd[`KBCEFG_GATE_DATA_BIT];
            state_next.gate_st = GT_GOT_DATA;
          end
          GT_GOT_DATA: begin
            state_next.in_data = cmd;
            state_next.cd = 1'b0;
            state_next.in_full_flag = 1'b1;
            state_next.gate_st = GT_IDLE;
          end
          default: begin
            state_next.in_data = cmd;
            state_next.cd = 1'b0;
            state_next.in_full_flag = 1'b1;
            state_next.gate_st = GT_IDLE;
          end
        endcase
      end

      // Fast-reset port write
      if (host_req.wr && hit_fr) begin
        state_next.fast_reset = host_req.wdata;
      end

      // Firmware writes last, so a flag set beats a host-read clear
      if (ec_req.wr) begin
        case (ec_req.addr)
          `KBCEFG_EC_KBD_DATA: begin
            state_next.out_data = ec_req.wdata;
            state_next.out_full_flag = 1'b1;
            state_next.kbd_track = 1'b1;
          end
          `KBCEFG_AUX_OUTPUT_DATA_WRITE: begin
            state_next.out_data = ec_req.wdata;
            state_next.out_full_flag = 1'b1;
            if (!state_reg.aux_fw_sel) begin
              state_next.aux_flag = 1'b1;
            end
          end
          `KBCEFG_EC_STATUS: begin
            state_next.ud[0] = ec_req.wdata[2];
            state_next.ud[1] = ec_req.wdata[4];
            state_next.ud[2] = ec_req.wdata[6];
            state_next.ud[3] = ec_req.wdata[7];
            if (state_reg.aux_fw_sel) begin
              state_next.aux_flag = ec_req.wdata[`KBCEFG_ST_AUX];
            end
          end
          `KBCEFG_EC_CONTROL: begin
            state_next.irq_en = ec_req.wdata[`KBCEFG_CTL_IRQEN];
            state_next.kbd_fw_sel = ec_req.wdata[`KBCEFG_CTL_KBDFW];
            state_next.aux_fw_sel = ec_req.wdata[`KBCEFG_CTL_AUXFW];
            state_next.gate_ovr = ec_req.wdata[`KBCEFG_CTL_GATEOVR];
          end
          `KBCEFG_EC_KBD_FLAG: begin
            state_next.kbd_latch = ec_req.wdata[0];
          end
          `KBCEFG_EC_ACTIVATE: begin
            state_next.activate = ec_req.wdata[0];
          end
          `KBCEFG_EC_FR_ENABLE: begin
            state_next.fr_enable = ec_req.wdata[0];
          end
          `KBCEFG_EC_FR_BAR: begin
            state_next.fr_valid = ec_req.wdata[0];
          end
          `KBCEFG_EC_GATE_CTRL: begin
            state_next.gate_fw = ec_req.wdata[0];
          end
          `KBCEFG_EC_GATE_SET: begin
            state_next.gate_host = 1'b1;
          end
          `KBCEFG_EC_GATE_CLR: begin
            state_next.gate_host = 1'b0;
          end
          default: begin
            state_next.ud = state_next.ud;
          end
        endcase
      end

      // Registered system outputs; an inactive interface holds both interrupts low
      state_next.keyboard_irq = state_next.activate && state_next.irq_en
        && kbd_flag(state_next);
      state_next.mouse_irq = state_next.activate && state_next.irq_en
        && state_next.aux_flag;
      state_next.addr_line_gate = gate_value(state_next);
    end
    // I/O-domain reset still reaches the port while everything else is frozen
    if (!io_domain_reset_n) begin
      state_next.fast_reset = `KBCEFG_FAST_RESET_RST;
    end
    state_next.alt_line_gate = state_next.fast_reset[`KBCEFG_FR_GATE_BIT];
    state_next.alt_host_reset_n = !state_next.fast_reset[`KBCEFG_FR_RST_BIT];
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign host_rdata = state_reg.host_rdata;
  assign host_rdata_oe = state_reg.host_rdata_oe;
  assign ec_rdata = state_reg.ec_rdata;
  assign keyboard_irq = state_reg.keyboard_irq;
  assign mouse_irq = state_reg.mouse_irq;
  assign addr_line_gate = state_reg.addr_line_gate;
  assign alt_line_gate = state_reg.alt_line_gate;
  assign alt_host_reset_n = state_reg.alt_host_reset_n;

endmodule

`default_nettype wire

// [kbcefg_host_bfm.sv]
// Host chipset model issuing single-cycle I/O reads and writes
`timescale 1ns/100ps
`default_nettype none
module kbcefg_host_bfm
  import kbcefg_pkg::*;
(
  // Clock
  input wire logic clk,
  // Host I/O cycle
  output var kbcefg_host_req_t host_req
);
  initial host_req = '{wr: 1'b0, rd: 1'b0, addr: 16'hFFFF, wdata: 8'h5A};

  task automatic io_cycle(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    host_req <= '{wr: w, rd: !w, addr: a, wdata: w ? d : ~host_req.wdata};
    @(negedge clk);
    // Released lines wander so stale values are never trusted
    host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// [kbcefg_monitor.sv]
// Port checker of the keyboard-controller assist block
`timescale 1ns/100ps
`default_nettype none
`include "kbcefg_params.svh"
module kbcefg_monitor
  import kbcefg_pkg::*;
#(
  parameter logic [15:0] KBC_BASE = `KBCEFG_KBC_BASE_DEF
) (
  // Clock, resets and low-power request
  input wire logic clk,
  input wire logic reset_n,
  input wire logic io_domain_reset_n,
  input wire logic low_power_req,
  // Requests
  input wire kbcefg_host_req_t host_req,
  input wire kbcefg_ec_req_t ec_req,
  // Answers and system lines
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_oe,
  input wire logic [7:0] ec_rdata,
  input wire logic keyboard_irq,
  input wire logic mouse_irq,
  input wire logic addr_line_gate,
  input wire logic alt_line_gate,
  input wire logic alt_host_reset_n
);
  // Shadows of control bits, rebuilt from accepted writes
  logic en_q, kfw_q, afw_q, ovr_q, act_q, fre_q, d1_q, hb_q, gw_q;
  wire logic ecw = ec_req.wr && !low_power_req;
  wire logic hw = host_req.wr && !low_power_req && act_q;
  wire logic hdat = hw && host_req.addr == KBC_BASE;
  wire logic hcmd = hw && host_req.addr == KBC_BASE + 16'h0004;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {en_q, kfw_q, afw_q, ovr_q, act_q, fre_q, d1_q, hb_q, gw_q} <= '0;
    end else begin
      if (ecw && ec_req.addr == `KBCEFG_EC_CONTROL) begin
        {ovr_q, afw_q, kfw_q, en_q} <= ec_req.wdata[3:0];
      end
      if (ecw && ec_req.addr == `KBCEFG_EC_ACTIVATE) act_q <= ec_req.wdata[0];
      if (ecw && ec_req.addr == `KBCEFG_EC_FR_ENABLE) fre_q <= ec_req.wdata[0];
      if (ecw && ec_req.addr == `KBCEFG_EC_GATE_CTRL) gw_q <= ec_req.wdata[0];
      if (hdat || hcmd) begin
        d1_q <= hcmd && host_req.wdata == `KBCEFG_CMD_GATE;
        hb_q <= host_req.wdata[1];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  kbd_irq_off_a: assert property (!en_q && !$past(en_q) |-> !keyboard_irq)
    else $error("keyboard interrupt high while disabled");
  mouse_irq_off_a: assert property (!en_q && !$past(en_q) |-> !mouse_irq)
    else $error("mouse interrupt high while disabled");
  kbd_irq_rise_a: assert property (ecw && ec_req.addr == `KBCEFG_EC_KBD_DATA && en_q
    && !kfw_q && act_q |=> keyboard_irq) else $error("keyboard interrupt missed");
  mouse_irq_rise_a: assert property (ecw && ec_req.addr == `KBCEFG_AUX_OUTPUT_DATA_WRITE && en_q
    && !afw_q && act_q |=> mouse_irq) else $error("mouse interrupt missed");
  port_io_reset_a: assert property (!io_domain_reset_n |=> !alt_line_gate && alt_host_reset_n)
    else $error("fast-reset port kept state over reset");
  port_off_read_a: assert property (host_req.rd && host_req.addr == 16'h0092 && !fre_q
    && !low_power_req |=> !host_rdata_oe) else $error("disabled port drove the bus");
  gate_override_a: assert property (ecw && ec_req.addr == `KBCEFG_EC_GATE_CTRL && ovr_q
    |=> addr_line_gate == gw_q) else $error("gate ignores firmware bit");
  gate_sequence_a: assert property (hdat && d1_q && !ovr_q
    |=> addr_line_gate == hb_q) else $error("gate ignores data bit 1");
  gate_latch_a: assert property (ecw && !ovr_q && (ec_req.addr == `KBCEFG_EC_GATE_SET
    || ec_req.addr == `KBCEFG_EC_GATE_CLR) |=>
    addr_line_gate == ($past(ec_req.addr) == `KBCEFG_EC_GATE_SET))
    else $error("gate latch set or clear lost");
  low_power_hold_a: assert property (low_power_req |=> $stable(keyboard_irq)
    && $stable(mouse_irq) && $stable(addr_line_gate)) else $error("outputs moved in low power");
endmodule
bind kbcefg_core kbcefg_monitor #(.KBC_BASE(KBC_BASE)) u_monitor (.clk(clk), .reset_n(reset_n),
  .io_domain_reset_n(io_domain_reset_n), .low_power_req(low_power_req), .host_req(host_req),
  .ec_req(ec_req), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
  .ec_rdata(ec_rdata), .keyboard_irq(keyboard_irq), .mouse_irq(mouse_irq),
  .addr_line_gate(addr_line_gate), .alt_line_gate(alt_line_gate),
  .alt_host_reset_n(alt_host_reset_n));
`default_nettype wire

// [kbc_emulation_flags_gate_a20_tb.sv]
// Self-checking bench of the keyboard-controller assist block
`timescale 1ns/100ps
`default_nettype none
module kbc_emulation_flags_gate_a20_tb;
  import kbcefg_pkg::*;
  localparam logic [15:0] BASE = 16'h0060;
  localparam logic [15:0] CMD = 16'h0064;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic io_domain_reset_n = 1'b1;
  logic low_power_req = 1'b0;
  kbcefg_host_req_t host_req;
  kbcefg_ec_req_t ec_req = '0;
  logic [7:0] host_rdata, ec_rdata, d, c;
  logic host_rdata_oe, keyboard_irq, mouse_irq, addr_line_gate, alt_line_gate, alt_host_reset_n;
  logic hrd_d = 1'b0;
  logic erd_d = 1'b0;
  logic [16:0] expq[$];
  logic [16:0] e;
  int fails = 0;
  int total_checks = 0;
  wire logic [4:0] lines = {keyboard_irq, mouse_irq, addr_line_gate, alt_line_gate,
    alt_host_reset_n};

  initial forever #50 clk = ~clk;

  kbcefg_core DUT (.clk(clk), .reset_n(reset_n), .io_domain_reset_n(io_domain_reset_n),
    .low_power_req(low_power_req), .host_req(host_req), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .ec_req(ec_req), .ec_rdata(ec_rdata),
    .keyboard_irq(keyboard_irq), .mouse_irq(mouse_irq), .addr_line_gate(addr_line_gate),
    .alt_line_gate(alt_line_gate), .alt_host_reset_n(alt_host_reset_n));
  kbcefg_host_bfm HOST (.clk(clk), .host_req(host_req));

  task automatic stop_test;
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic lv(input logic [4:0] exp);
    repeat (2) @(negedge clk);
    chk({4'h0, lines}, {4'h0, exp});
  endtask

  // Reads note {mask, drive expected, data}; the watcher compares
  task automatic ec_op(input logic w, input logic [11:0] a, input logic [7:0] v,
      input logic [7:0] m);
    if (!w) expq.push_back({m, 1'b1, v & m});
    @(negedge clk);
    ec_req <= '{wr: w, rd: !w, addr: a, wdata: v};
    @(negedge clk);
    ec_req <= '0;
  endtask

  task automatic host_op(input logic w, input logic [15:0] a, input logic [7:0] v,
      input logic oe, input logic [7:0] m);
    if (!w) expq.push_back({m, oe, v & m});
    HOST.io_cycle(w, a, v);
  endtask

  always @(posedge clk) begin
    hrd_d <= host_req.rd;
    erd_d <= ec_req.rd;
  end

  always @(negedge clk) begin
    if (hrd_d || erd_d) begin
      e = expq.pop_front();
      if (hrd_d) chk({host_rdata_oe, host_rdata & e[16:9] & {8{host_rdata_oe}}}, e[8:0]);
      else chk({1'b1, ec_rdata & e[16:9]}, e[8:0]);
    end
  end

  // Hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    #2000000;
    fails++;
    stop_test;
  end

  initial begin
    void'($urandom(32'h206F));
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    lv(5'b00001);
    host_op(1'b0, BASE, 8'h00, 1'b0, 8'h00);
    ec_op(1'b0, 12'h014, 8'h00, 8'hFF);
    ec_op(1'b1, 12'h030, 8'h01, 8'h00);
    d = 8'($urandom);
    ec_op(1'b1, 12'h000, d, 8'h00);
    ec_op(1'b0, 12'h004, 8'h01, 8'hFF);
    lv(5'b00001);
    ec_op(1'b1, 12'h008, 8'h01, 8'h00);
    lv(5'b10001);
    ec_op(1'b0, 12'h014, 8'h01, 8'h01);
    host_op(1'b0, BASE, d, 1'b1, 8'hFF);
    lv(5'b00001);
    d = 8'($urandom);
    ec_op(1'b1, 12'h00C, d, 8'h00);
    lv(5'b01001);
    host_op(1'b0, BASE, d, 1'b1, 8'hFF);
    lv(5'b00001);
    ec_op(1'b1, 12'h008, 8'h00, 8'h00);
    ec_op(1'b1, 12'h00C, d, 8'h00);
    lv(5'b00001);
    host_op(1'b0, BASE, d, 1'b1, 8'hFF);
    ec_op(1'b1, 12'h008, 8'h05, 8'h00);
    ec_op(1'b1, 12'h004, 8'h20, 8'h00);
    lv(5'b01001);
    ec_op(1'b1, 12'h004, 8'h00, 8'h00);
    lv(5'b00001);
    ec_op(1'b1, 12'h008, 8'h03, 8'h00);
    ec_op(1'b1, 12'h014, 8'h01, 8'h00);
    host_op(1'b0, BASE, d, 1'b1, 8'hFF);
    lv(5'b10001);
    ec_op(1'b1, 12'h014, 8'h00, 8'h00);
    lv(5'b00001);
    ec_op(1'b1, 12'h008, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++) begin
      repeat (i / 2 + 1) host_op(1'b1, CMD, 8'hD1, 1'b0, 8'h00);
      host_op(1'b1, BASE, i[0] ? 8'hDD : 8'hDF, 1'b0, 8'h00);
      lv({2'b00, !i[0], 2'b01});
      host_op(1'b1, CMD, i[1] ? 8'hFE : 8'hFF, 1'b0, 8'h00);
      ec_op(1'b0, 12'h004, 8'h00, 8'h03);
    end
    c = 8'($urandom_range(207));
    host_op(1'b1, CMD, 8'hD1, 1'b0, 8'h00);
    host_op(1'b1, CMD, c, 1'b0, 8'h00);
    ec_op(1'b0, 12'h004, 8'h0A, 8'h0A);
    lv(5'b00101);
    ec_op(1'b0, 12'h000, c, 8'hFF);
    host_op(1'b1, CMD, 8'hD1, 1'b0, 8'h00);
    host_op(1'b1, BASE, 8'hDF, 1'b0, 8'h00);
    host_op(1'b1, BASE, 8'hDD, 1'b0, 8'h00);
    ec_op(1'b0, 12'h004, 8'h02, 8'h02);
    ec_op(1'b0, 12'h000, 8'h00, 8'h00);
    d = 8'($urandom);
    host_op(1'b1, BASE, d, 1'b0, 8'h00);
    ec_op(1'b0, 12'h004, 8'h02, 8'h0A);
    ec_op(1'b0, 12'h000, d, 8'hFF);
    host_op(1'b1, CMD, c, 1'b0, 8'h00);
    ec_op(1'b0, 12'h004, 8'h0A, 8'h0A);
    ec_op(1'b0, 12'h000, c, 8'hFF);
    ec_op(1'b1, 12'h108, d, 8'h00);
    lv(5'b00001);
    ec_op(1'b1, 12'h008, 8'h08, 8'h00);
    ec_op(1'b1, 12'h100, 8'h01, 8'h00);
    lv(5'b00101);
    ec_op(1'b0, 12'h100, 8'h01, 8'h01);
    ec_op(1'b1, 12'h100, 8'h00, 8'h00);
    ec_op(1'b1, 12'h008, 8'h00, 8'h00);
    ec_op(1'b1, 12'h104, c, 8'h00);
    lv(5'b00101);
    ec_op(1'b0, 12'h100, 8'h01, 8'h01);
    host_op(1'b1, 16'h0092, 8'h03, 1'b0, 8'h00);
    lv(5'b00101);
    host_op(1'b0, 16'h0092, 8'h00, 1'b0, 8'h00);
    ec_op(1'b1, 12'h040, 8'h01, 8'h00);
    ec_op(1'b1, 12'h044, 8'hFF, 8'h00);
    ec_op(1'b0, 12'h044, 8'h01, 8'hFF);
    host_op(1'b1, 16'h0092, 8'h03, 1'b0, 8'h00);
    lv(5'b00110);
    host_op(1'b0, 16'h0092, 8'h03, 1'b1, 8'hFF);
    io_domain_reset_n = 1'b0;
    @(negedge clk);
    io_domain_reset_n = 1'b1;
    lv(5'b00101);
    host_op(1'b0, 16'h0092, 8'h00, 1'b1, 8'hFF);
    host_op(1'b0, 16'h0070, 8'h00, 1'b0, 8'h00);
    ec_op(1'b0, 12'h0FC, 8'h00, 8'hFF);
    ec_op(1'b1, 12'h008, 8'h01, 8'h00);
    low_power_req = 1'b1;
    ec_op(1'b1, 12'h000, d, 8'h00);
    lv(5'b00101);
    low_power_req = 1'b0;
    ec_op(1'b1, 12'h000, d, 8'h00);
    lv(5'b10101);
    stop_test;
  end
endmodule
`default_nettype wire
